/* src/qdsc_top.sv */
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module qdsc_top
   import qdsc_pkg::*;
#(
   parameter int WDOG_LIMIT = qdsc_pkg::WDOG_CYCLES
) (
   // system clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // serial link, clocked by the host
   input  wire logic        serial_clk,
   input  wire logic        frame_sync_n,
   input  wire logic        serial_data_in,
   output logic             serial_data_out,
   output logic             serial_data_out_oe,
   // update and clear pins
   input  wire logic        load_update_n,
   input  wire logic        clear_in,
   // status pins
   input  wire logic        power_on_condition_in,
   input  wire logic        hw_reset_n,
   output logic             alert_out,
   output logic             fault_n_out,
   output logic             fault_n_oe,
   // channel outputs
   output logic [NUM_CH*DATA_BITS-1:0] dac_out,
   output logic [NUM_CH*2-1:0]         ch_mode
);
   import qdsc_pkg::*;

   // ---------------- link domain ----------------
   // link flops have no reset pin of their own; start values keep toggles defined
   logic [FRAME_BITS-1:0] shift_q     = '0;
   logic [4:0]            bitcnt_q    = 5'h0;
   logic [FRAME_BITS-1:0] word_q      = '0;
   logic                  word_tgl_q  = 1'b0;
   logic                  act_tgl_q   = 1'b0;
   logic [FRAME_BITS-1:0] rdsh_q      = '0;
   logic                  rd_tgl_s1_q = 1'b0;
   logic                  rd_tgl_s2_q = 1'b0;
   logic                  rd_seen_q   = 1'b0;
   logic                  rd_tgl_q;
   logic [FRAME_BITS-1:0] rd_word_q;

   // shifter only moves while framed; a full word is latched and toggled
   always_ff @(negedge serial_clk) begin
      if (!frame_sync_n) begin
         shift_q   <= {shift_q[FRAME_BITS-2:0], serial_data_in};
         act_tgl_q <= ~act_tgl_q;
         if (bitcnt_q == 5'(FRAME_BITS - 1)) begin
            bitcnt_q   <= 5'h0;
            word_q     <= {shift_q[FRAME_BITS-2:0], serial_data_in};
            word_tgl_q <= ~word_tgl_q;
         end else begin
            bitcnt_q <= bitcnt_q + 5'h1;
         end
      end else begin
         bitcnt_q <= 5'h0;  // a short frame is dropped at the next fall outside a frame, bits stay put
      end
   end

   // readback word crosses by toggle; loaded at frame start on the link side
   always_ff @(posedge serial_clk) begin
      rd_tgl_s1_q <= rd_tgl_q;
      rd_tgl_s2_q <= rd_tgl_s1_q;
      if (frame_sync_n) begin
         rd_seen_q <= rd_seen_q;
      end else if (rd_tgl_s2_q != rd_seen_q && bitcnt_q == 5'h1) begin
         // first rise of a frame follows the first fall, so the count is one here
         rd_seen_q <= rd_tgl_s2_q;
         rdsh_q    <= rd_word_q;
      end else begin
         rdsh_q <= {rdsh_q[FRAME_BITS-2:0], 1'b0};
      end
   end

   // output pin only driven inside a frame
   assign serial_data_out    = rdsh_q[FRAME_BITS-1];
   assign serial_data_out_oe = ~frame_sync_n;

   // ---------------- system domain ----------------
   logic rst_n;
   logic load_update_n_s, clr_s, poc_s, hwrst_s, fs_s, word_s, act_s;

   qdsc_sync #(.W(7)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({load_update_n, clear_in, power_on_condition_in, hw_reset_n,
                 frame_sync_n, word_tgl_q, act_tgl_q}),
      .q       ({load_update_n_s, clr_s, poc_s, hwrst_s, fs_s, word_s, act_s})
   );

   // hardware reset pin resets logic alongside the bus reset
   assign rst_n = aresetn & hwrst_s;

   logic                   word_prev_q, act_prev_q, load_update_n_prev_q, clr_prev_q;
   logic [FRAME_BITS-1:0]  rx_word_q;
   logic                   rx_stb;
   logic                   wr_pend_q;
   logic [DATA_BITS-1:0]   in_reg_q  [NUM_CH];
   logic [DATA_BITS-1:0]   out_reg_q [NUM_CH];
   logic [DATA_BITS-1:0]   clr_code_q;
   logic [NUM_CH-1:0]      clr_en_q;
   logic [NUM_CH-1:0]      upd_pend_q;
   logic [1:0]             addr_ch;
   logic [1:0]             cmd;
   logic [31:0]            ctrl_q;
   logic                   poc_taken_q;
   logic [1:0]             start_mode_q;
   logic [31:0]            wdog_q;
   logic                   alert_q;
   logic                   fault_q;

   // word is stable long before its toggle arrives through two flops
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         word_prev_q <= 1'b0;
         act_prev_q  <= 1'b0;
         load_update_n_prev_q <= 1'b1;
         clr_prev_q  <= 1'b0;
         rx_word_q   <= '0;
         wr_pend_q   <= 1'b0;
      end else begin
         word_prev_q <= word_s;
         act_prev_q  <= act_s;
         load_update_n_prev_q <= load_update_n_s;
         clr_prev_q  <= clr_s;
         if (word_s != word_prev_q) begin
            rx_word_q <= word_q;
            wr_pend_q <= 1'b1;
         end else if (fs_s) begin
            wr_pend_q <= 1'b0;  // apply once the frame has ended
         end
      end
   end

   // frame end after a full word triggers the command
   assign rx_stb  = wr_pend_q & fs_s;
   assign cmd     = rx_word_q[CMD_HI:CMD_LO];
   assign addr_ch = rx_word_q[CH_HI:CH_LO];

   // channel registers, clear has priority and blocks output writes
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_CH; i++) begin
            in_reg_q[i]  <= '0;
            out_reg_q[i] <= '0;
         end
         clr_code_q <= '0;
         clr_en_q   <= '0;
         upd_pend_q <= '0;
      end else begin
         if (rx_stb && cmd == CMD_WRITE) begin
            in_reg_q[addr_ch] <= rx_word_q[DATA_BITS-1:0];
            if (load_update_n_s) begin
               upd_pend_q[addr_ch] <= 1'b1;
            end
         end
         if (rx_stb && cmd == CMD_CLR_CODE) begin
            clr_code_q <= rx_word_q[DATA_BITS-1:0];
         end
         if (rx_stb && cmd == CMD_CLR_EN) begin
            clr_en_q <= rx_word_q[NUM_CH-1:0];
         end
         if (clr_s && !clr_prev_q) begin
            for (int i = 0; i < NUM_CH; i++) begin
               if (clr_en_q[i]) begin
                  out_reg_q[i] <= clr_code_q;
               end
            end
         end else if (!clr_s) begin
            if (rx_stb && cmd == CMD_WRITE && !load_update_n_s) begin
               out_reg_q[addr_ch] <= rx_word_q[DATA_BITS-1:0];
            end else if (!load_update_n_s && load_update_n_prev_q) begin
               for (int i = 0; i < NUM_CH; i++) begin
                  if (upd_pend_q[i]) begin
                     out_reg_q[i] <= in_reg_q[i];
                  end
               end
               upd_pend_q <= '0;
            end
         end
      end
   end

   // readback word: addressed output register, handed to link by toggle
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         rd_tgl_q  <= 1'b0;
         rd_word_q <= '0;
      end else if (rx_stb && cmd == CMD_READBACK) begin
         rd_word_q <= {rx_word_q[CMD_HI:CH_LO], 4'h0, out_reg_q[addr_ch]};
         rd_tgl_q  <= ~rd_tgl_q;
      end
   end

   // power-on condition caught once after each reset release
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         poc_taken_q  <= 1'b0;
         start_mode_q <= QDSC_OUT_TRISTATE;
      end else if (!poc_taken_q) begin
         poc_taken_q  <= 1'b1;
         start_mode_q <= poc_s ? QDSC_OUT_PULLDOWN : QDSC_OUT_TRISTATE;
      end
   end

   // every channel mode follows the strap: pulldown when set, tristate otherwise
   always_comb begin
      dac_out = '0;
      ch_mode = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         dac_out[i*DATA_BITS +: DATA_BITS] = out_reg_q[i];
         ch_mode[i*2 +: 2] = start_mode_q;
      end
   end

   // inactivity watchdog; a framed serial clock fall or a low frame sync restarts it
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         wdog_q  <= '0;
         alert_q <= 1'b0;
      end else if (act_s != act_prev_q || !fs_s) begin
         wdog_q  <= '0;
         alert_q <= 1'b0;
      end else if (wdog_q >= 32'(WDOG_LIMIT - 1)) begin
         alert_q <= 1'b1;
      end else begin
         wdog_q <= wdog_q + 32'h1;
      end
   end
   assign alert_out = alert_q;

   // fault sources are the open, short, overtemp and pec ctrl bits, written over axi
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= ctrl_q[CTRL_OPEN_BIT] | ctrl_q[CTRL_SHORT_BIT] |
                    ctrl_q[CTRL_OTEMP_BIT] | ctrl_q[CTRL_PEC_BIT];
      end
   end
   // open drain: only ever drive low
   assign fault_n_out = 1'b0;
   assign fault_n_oe  = fault_q;

   // ---------------- axi4-lite slave ----------------
   logic        aw_have_q, w_have_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        do_write;
   logic [31:0] rd_mux;
   logic        rd_ok;

   assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
   assign do_write      = aw_have_q & w_have_q;

   // capture address and data in either order, answer when both held
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         aw_have_q    <= 1'b0;
         w_have_q     <= 1'b0;
         aw_addr_q    <= '0;
         w_data_q     <= '0;
         w_strb_q     <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         ctrl_q       <= CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= RESP_SLVERR;
            if (aw_addr_q == REG_CTRL) begin
               s_axi_bresp <= RESP_OKAY;
               for (int b = 0; b < 4; b++) begin
                  if (w_strb_q[b]) begin
                     ctrl_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
                  end
               end
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read decode: ctrl, status, four output codes
   always_comb begin
      rd_mux = 32'h0;
      rd_ok  = 1'b1;
      if (s_axi_araddr == REG_CTRL) begin
         rd_mux = ctrl_q;
      end else if (s_axi_araddr == REG_STATUS) begin
         rd_mux = {20'h0, clr_en_q, upd_pend_q, start_mode_q, fault_q, alert_q};
      end else if (s_axi_araddr[7:4] == REG_DAC0[7:4] && s_axi_araddr[1:0] == 2'h0) begin
         rd_mux = {16'h0, out_reg_q[s_axi_araddr[3:2]]};
      end else begin
         rd_ok = 1'b0;
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;

   // read answer one cycle after address taken
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* src/qdsc_pkg.sv */
package qdsc_pkg;
   // frame layout: 24-bit word, [23:22] command, [21:20] channel, [15:0] data
   localparam int FRAME_BITS    = 24;
   localparam int CMD_HI        = 23;
   localparam int CMD_LO        = 22;
   localparam int CH_HI         = 21;
   localparam int CH_LO         = 20;
   localparam int DATA_BITS     = 16;
   localparam int NUM_CH        = 4;
   localparam logic [1:0] CMD_WRITE     = 2'h0;
   localparam logic [1:0] CMD_CLR_CODE  = 2'h1;
   localparam logic [1:0] CMD_CLR_EN    = 2'h2;
   localparam logic [1:0] CMD_READBACK  = 2'h3;
   // timing
   localparam int CLK_HZ         = 20_000_000;
   localparam int WDOG_TIME_MS   = 100;
   localparam int WDOG_CYCLES    = CLK_HZ / 1000 * WDOG_TIME_MS;
   // axi register offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_DAC0   = 8'h10;
   // ctrl field positions
   localparam int CTRL_OPEN_BIT  = 0;
   localparam int CTRL_SHORT_BIT = 1;
   localparam int CTRL_OTEMP_BIT = 2;
   localparam int CTRL_PEC_BIT   = 3;
   localparam logic [31:0] CTRL_RESET = 32'h0;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // output state after reset
   typedef enum logic [1:0] {
      QDSC_OUT_TRISTATE = 2'h0,
      QDSC_OUT_PULLDOWN = 2'h1,
      QDSC_OUT_ACTIVE   = 2'h2
   } qdsc_outmode_e;
endpackage

/* src/qdsc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two flip-flop level synchroniser; stage one is read only by stage two
module qdsc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // data
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta_q;

   // double register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* testbench/qdsc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module qdsc_monitor
   import qdsc_pkg::*;
#(
   parameter int WDOG_LIMIT = 50
) (
   // clock and resets
   input wire logic                        aclk,
   input wire logic                        aresetn,
   input wire logic                        hw_reset_n,
   // link and control pins
   input wire logic                        serial_clk,
   input wire logic                        frame_sync_n,
   input wire logic                        serial_data_out_oe,
   input wire logic                        load_update_n,
   input wire logic                        clear_in,
   input wire logic                        power_on_condition_in,
   // status and channel outputs
   input wire logic                        alert_out,
   input wire logic                        fault_n_out,
   input wire logic                        fault_n_oe,
   input wire logic [NUM_CH*DATA_BITS-1:0] dac_out,
   input wire logic [NUM_CH*2-1:0]         ch_mode
);
   logic [31:0] quiet_q;

   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // link idle time in system cycles; sampled clock may alias, so limits carry margin
   always_ff @(posedge aclk) begin
      if (!aresetn || !hw_reset_n || !frame_sync_n || $changed(serial_clk)) begin
         quiet_q <= 32'h0;
      end else begin
         quiet_q <= quiet_q + 32'h1;
      end
   end

   a_fault_open_drain: assert property (fault_n_oe |-> !fault_n_out)
      else $error("fault line driven high");
   a_oe_in_frame: assert property ((!frame_sync_n) [*2] |-> serial_data_out_oe)
      else $error("readback output off in frame");
   a_alert_not_early: assert property ($rose(alert_out) |-> quiet_q >= WDOG_LIMIT - 1)
      else $error("alert before idle limit");
   a_alert_not_late: assert property (frame_sync_n && quiet_q > WDOG_LIMIT + 8 |-> alert_out)
      else $error("alert missing after idle limit");
   a_alert_clears: assert property (alert_out && !frame_sync_n |-> ##[1:8] !alert_out)
      else $error("alert kept during activity");
   a_hwrst_outs: assert property (!hw_reset_n [*5] |-> dac_out == '0 && !fault_n_oe)
      else $error("outputs live in hardware reset");
   a_strap_mode: assert property ($rose(aresetn) |-> ##3
      ch_mode == {NUM_CH{1'b0, power_on_condition_in}})
      else $error("channel mode not from strap");
   a_clear_blocks: assert property (clear_in [*6] |=> $stable(dac_out))
      else $error("output written while clear high");
   a_load_defers: assert property ((load_update_n && !clear_in) [*6] |=> $stable(dac_out))
      else $error("output moved with load high");

   c_alert: cover property ($rose(alert_out));
   c_clear: cover property ($rose(clear_in) ##8 clear_in);
   c_fault: cover property ($rose(fault_n_oe));
endmodule

bind qdsc_top qdsc_monitor #(.WDOG_LIMIT(WDOG_LIMIT)) u_mon (
   .aclk, .aresetn, .hw_reset_n, .serial_clk, .frame_sync_n, .serial_data_out_oe,
   .load_update_n, .clear_in, .power_on_condition_in, .alert_out, .fault_n_out,
   .fault_n_oe, .dac_out, .ch_mode
);
`default_nettype wire

/* testbench/qdsc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module qdsc_host (
   // serial pins toward the device
   output logic      serial_clk,
   output logic      frame_sync_n,
   output logic      serial_data_in,
   // readback from the device
   input  wire logic serial_data_out,
   input  wire logic serial_data_out_oe
);
   // clock stands still high between frames
   initial begin
      serial_clk = 1'b1;
      frame_sync_n = 1'b1;
      serial_data_in = 1'b0;
   end
   // one 24-bit frame msb first, 12 ns clock; readback taken before each fall but the first, and after the last rise
   task automatic send(input logic [23:0] w, output logic [23:0] r);
      #3 frame_sync_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         serial_data_in = w[i];
         #6;
         if (i < 23) r = {r[22:0], serial_data_out};
         serial_clk = 1'b0;
         #6 serial_clk = 1'b1;
      end
      #6 r = {r[22:0], serial_data_out};
      frame_sync_n = 1'b1;
      serial_data_in = ~serial_data_in; // no stale bit once released
   endtask
   // clock edges with the frame idle, which the device must ignore
   task automatic stray(input int n);
      repeat (n) begin
         #6 serial_clk = 1'b0;
         #6 serial_clk = 1'b1;
      end
   endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
   import qdsc_pkg::*;
   localparam int WDL = 50;
   int          n_mismatch = 0, checked = 0;
   logic        aclk = 1'b0, aresetn = 1'b0, hw_reset_n = 1'b1, load_update_n = 1'b0;
   logic        clear_in = 1'b0, power_on_condition_in = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, alert_out, fault_n_out, fault_n_oe;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        serial_clk, frame_sync_n, serial_data_in, serial_data_out, serial_data_out_oe;
   logic [NUM_CH*DATA_BITS-1:0] dac_out;
   logic [NUM_CH*2-1:0]         ch_mode;
   logic [23:0] rx;

   // short idle limit keeps the alert reachable
   qdsc_top #(.WDOG_LIMIT(WDL)) dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_clk, .frame_sync_n,
      .serial_data_in, .serial_data_out, .serial_data_out_oe, .load_update_n, .clear_in,
      .power_on_condition_in, .hw_reset_n, .alert_out, .fault_n_out, .fault_n_oe,
      .dac_out, .ch_mode
   );
   qdsc_host u_host (
      .serial_clk, .frame_sync_n, .serial_data_in, .serial_data_out, .serial_data_out_oe
   );

   // 20 mhz system clock
   initial begin
      forever #25 aclk = ~aclk;
   end

   task automatic cycles(input int n);
      repeat (n) @(posedge aclk);
   endtask

   function automatic logic [23:0] wd(input logic [1:0] c, input logic [1:0] n,
                                      input logic [15:0] d);
      return {c, n, 4'h0, d};
   endfunction

   // one frame, then time for the word to cross into the system domain
   task automatic lnk(input logic [23:0] w);
      u_host.send(w, rx);
      @(posedge aclk);
      cycles(8);
   endtask

   // address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
         s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
      end while (((s_axi_awvalid & ~s_axi_awready) | (s_axi_wvalid & ~s_axi_wready)) && n < 64);
      while (!s_axi_bvalid && n < 64) begin
         @(posedge aclk);
         n++;
      end
      if (n >= 64) n_mismatch++;
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (!s_axi_arready && n < 64);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid && n < 64) begin
         @(posedge aclk);
         n++;
      end
      if (n >= 64) n_mismatch++;
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic t_reset();
      logic [31:0] d;
      logic [1:0]  r;
      cycles(4);
      `CHK("mode", {NUM_CH{2'h1}}, ch_mode)
      `CHK("dac", 64'h0, dac_out)
      axi_rd(REG_CTRL, d, r);
      `CHK("ctrl", CTRL_RESET, d)
   endtask

   // idle link raises the alert; a write frame clears it
   task automatic t_alert();
      cycles(WDL + 12);
      `CHK("alert idle", 1'b1, alert_out)
      lnk(wd(CMD_WRITE, 2'h1, 16'h1111));
      `CHK("alert busy", 1'b0, alert_out)
      `CHK("ch1", 16'h1111, dac_out[31:16])
   endtask

   // load held high parks both writes until it falls
   task automatic t_load();
      load_update_n <= 1'b1;
      lnk(wd(CMD_WRITE, 2'h0, 16'h8765));
      lnk(wd(CMD_WRITE, 2'h3, 16'h4321));
      `CHK("ch0 parked", 16'h0, dac_out[15:0])
      `CHK("ch3 parked", 16'h0, dac_out[63:48])
      load_update_n <= 1'b0;
      cycles(8);
      `CHK("ch0", 16'h8765, dac_out[15:0])
      `CHK("ch3", 16'h4321, dac_out[63:48])
   endtask

   // stray clocks between request and answer must not shift the readback
   task automatic t_rdback();
      lnk(wd(CMD_READBACK, 2'h1, 16'h0));
      u_host.stray(5);
      lnk(wd(CMD_READBACK, 2'h1, 16'h0));
      `CHK("readback", {CMD_READBACK, 2'h1, 4'h0, 16'h1111}, rx)
   endtask

   task automatic t_clear();
      for (int c = 0; c < NUM_CH; c++) begin
         lnk(wd(CMD_CLR_CODE, 2'(c), 16'h0abc));
      end
      lnk(wd(CMD_CLR_EN, 2'h0, 16'h0005));
      clear_in <= 1'b1;
      cycles(8);
      `CHK("clr ch0", 16'h0abc, dac_out[15:0])
      `CHK("clr ch1", 16'h1111, dac_out[31:16])
      `CHK("clr ch2", 16'h0abc, dac_out[47:32])
      `CHK("clr ch3", 16'h4321, dac_out[63:48])
      lnk(wd(CMD_WRITE, 2'h1, 16'h2222));
      `CHK("blocked ch1", 16'h1111, dac_out[31:16])
      clear_in <= 1'b0;
   endtask

   // every forced fault source pulls the line; unmapped places are refused
   task automatic t_fault();
      logic [31:0] d;
      logic [1:0]  r;
      for (int b = 0; b < 4; b++) begin
         axi_wr(REG_CTRL, 32'h1 << b, r);
         cycles(3);
         `CHK("ctrl resp", RESP_OKAY, r)
         `CHK("fault oe", 1'b1, fault_n_oe)
         `CHK("fault lvl", 1'b0, fault_n_out)
         axi_wr(REG_CTRL, 32'h0, r);
         cycles(3);
         `CHK("fault off", 1'b0, fault_n_oe)
      end
      axi_wr(8'h08, 32'h1, r);
      `CHK("wr unmapped", RESP_SLVERR, r)
      axi_rd(8'h08, d, r);
      `CHK("rd unmapped", RESP_SLVERR, r)
      `CHK("rd data", 32'h0, d)
   endtask

   // hardware reset clears outputs; a second reset resamples the strap
   task automatic t_hwrst();
      hw_reset_n <= 1'b0;
      cycles(6);
      hw_reset_n <= 1'b1;
      cycles(4);
      `CHK("dac hw", 64'h0, dac_out)
      power_on_condition_in <= 1'b0;
      aresetn <= 1'b0;
      cycles(2);
      aresetn <= 1'b1;
      cycles(4);
      `CHK("mode 0", 8'h00, ch_mode)
   endtask

   task automatic summarize();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      cycles(16);
      aresetn <= 1'b1;
      t_reset();
      t_alert();
      t_load();
      t_rdback();
      t_clear();
      t_fault();
      t_hwrst();
      summarize();
   end

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #2000000;
      n_mismatch++;
      summarize();
   end
endmodule
`default_nettype wire
